/* File: cs_readout.sv */
// chip settings bank, its report readout and the pins it steers
`include "cs_defines.svh"
module cs_readout
  import cs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire cs_byte_t cmd_in,
  output logic cmd_ready_ff,
  output cs_byte_t rsp_out_ff,
  input wire logic rsp_ready,
  input wire cs_nvm_wr_t nvm_wr,
  input wire cs_activity_t activity,
  input wire cs_pin_en_t pin_en,
  output cs_pin_en_t pin_oe_ff,
  output cs_pin_en_t pin_val_ff,
  output logic serial_desc_en_ff,
  output logic cfg_locked_ff,
  output logic cfg_password_ff,
  output logic [1:0] dac_ref_level_ff,
  output logic dac_ref_internal_ff,
  output logic [4:0] dac_init_value_ff
);
  cs_state_t state_ff;
  cs_state_t nxt_state;
  logic [6:0] rx_idx_ff;
  logic [7:0] cmd_code_ff;
  logic [7:0] sub_code_ff;
  logic [6:0] tx_idx_ff;
  logic [2:0] fetch_idx_ff;
  logic [7:0] shadow_ff [3];
  logic [7:0] live_ind_ff;
  logic [7:0] live_clk_ff;
  logic [7:0] live_dac_ff;
  logic [7:0] mem_rd_data;
  logic [2:0] mem_rd_addr;
  logic supported;
  logic load_slot;
  logic clk_pin;

  // indicator level: idle bit, inverted while active
  function automatic logic led_level(input logic idle_bit, input logic active);
    return active ? ~idle_bit : idle_bit;
  endfunction

  assign supported = (sub_code_ff == `CS_SUB_CHIP_SETTINGS);
  assign load_slot = !rsp_out_ff.valid || rsp_ready;
  assign mem_rd_addr = fetch_idx_ff;

  cs_settings_mem #(
    .DEPTH(8),
    .AW(3)
  ) u_mem (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(nvm_wr.wr_en),
    .wr_addr(nvm_wr.addr),
    .wr_data(nvm_wr.data),
    .rd_addr(mem_rd_addr),
    .rd_data_ff(mem_rd_data)
  );

  // clock output divider
  cs_clk_div u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(pin_en.clk_out),
    .divider(live_clk_ff[`CS_CLKDIV_HI:0]),
    .clk_out_ff(clk_pin)
  );

  // live copy of the indicator, clock divider and DAC settings, written through with the store
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_ind_ff <= `CS_SETTING_RESET;
      live_clk_ff <= `CS_SETTING_RESET;
      live_dac_ff <= `CS_SETTING_RESET;
    end else if (nvm_wr.wr_en) begin
      if (nvm_wr.addr == `CS_MEM_IDX_INDICATOR) begin
        live_ind_ff <= nvm_wr.data;
      end
      if (nvm_wr.addr == `CS_MEM_IDX_CLKDIV) begin
        live_clk_ff <= nvm_wr.data;
      end
      if (nvm_wr.addr == `CS_MEM_IDX_DAC) begin
        live_dac_ff <= nvm_wr.data;
      end
    end
  end

  // command state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CS_RECV: begin
        if (cmd_in.valid && cmd_ready_ff && cmd_in.last) begin
          // only a read-flash report gets an answer
          if (rx_idx_ff == 7'h00) begin
            nxt_state = (cmd_in.data == `CS_CMD_READ_FLASH) ? CS_FETCH : CS_RECV;
          end else begin
            nxt_state = (cmd_code_ff == `CS_CMD_READ_FLASH) ? CS_FETCH : CS_RECV;
          end
        end
      end
      CS_FETCH: begin
        if (fetch_idx_ff == 3'h3) begin
          nxt_state = CS_SEND;
        end
      end
      CS_SEND: begin
        if (tx_idx_ff == `CS_REPORT_LEN && load_slot) begin
          nxt_state = CS_RECV;
        end
      end
      default: begin
        nxt_state = CS_RECV;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= CS_RECV;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready_ff <= 1'b0;
    end else begin
      cmd_ready_ff <= (nxt_state == CS_RECV);
    end
  end

  // capture of command and sub-code bytes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_idx_ff <= 7'h00;
      cmd_code_ff <= 8'h00;
      sub_code_ff <= 8'h00;
    end else if (state_ff == CS_RECV && cmd_in.valid && cmd_ready_ff) begin
      if (rx_idx_ff == 7'h00) begin
        cmd_code_ff <= cmd_in.data;
      end
      if (rx_idx_ff == 7'h01) begin
        sub_code_ff <= cmd_in.data;
      end
      if (cmd_in.last) begin
        rx_idx_ff <= 7'h00;
      end else if (rx_idx_ff != 7'h7F) begin
        rx_idx_ff <= rx_idx_ff + 7'h01;
      end
    end
  end

  // snapshot of the stored bytes through the registered read port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_idx_ff <= 3'h0;
    end else if (state_ff == CS_FETCH) begin
      fetch_idx_ff <= fetch_idx_ff + 3'h1;
    end else begin
      fetch_idx_ff <= 3'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_ff[0] <= `CS_SETTING_RESET;
      shadow_ff[1] <= `CS_SETTING_RESET;
      shadow_ff[2] <= `CS_SETTING_RESET;
    end else if (state_ff == CS_FETCH && fetch_idx_ff != 3'h0) begin
      shadow_ff[fetch_idx_ff[1:0] - 2'h1] <= mem_rd_data;
    end
  end

  // response byte for a given index
  function automatic logic [7:0] rsp_byte(input logic [6:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      7'h00: b = `CS_CMD_READ_FLASH;
      7'h01: b = supported ? `CS_STATUS_OK : `CS_STATUS_UNSUPPORTED;
      7'h02: b = supported ? `CS_STRUCT_LEN : 8'h00;
      `CS_OFS_INDICATOR: b = supported ? shadow_ff[0] : 8'h00;
      `CS_OFS_CLKDIV: b = supported ? {3'h0, shadow_ff[1][`CS_CLKDIV_HI:0]} : 8'h00;
      `CS_OFS_DAC: b = supported ? shadow_ff[2] : 8'h00;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // response stream with back-pressure
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_idx_ff <= 7'h00;
    end else if (state_ff != CS_SEND) begin
      tx_idx_ff <= 7'h00;
    end else if (load_slot && tx_idx_ff != `CS_REPORT_LEN) begin
      tx_idx_ff <= tx_idx_ff + 7'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_out_ff <= '0;
    end else if (state_ff == CS_SEND && load_slot) begin
      if (tx_idx_ff != `CS_REPORT_LEN) begin
        rsp_out_ff.valid <= 1'b1;
        rsp_out_ff.last <= (tx_idx_ff == `CS_REPORT_LEN - 7'h01);
        rsp_out_ff.data <= rsp_byte(tx_idx_ff);
      end else begin
        rsp_out_ff <= '0;
      end
    end else if (rsp_ready) begin
      rsp_out_ff.valid <= 1'b0;
    end
  end

  // drive only pins assigned to their function
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_ff <= '0;
    end else begin
      pin_oe_ff <= pin_en;
    end
  end

  // indicator and clock output pin levels
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_val_ff <= '0;
    end else begin
      pin_val_ff.rx_led <= pin_en.rx_led &&
        led_level(live_ind_ff[`CS_BIT_RX_IDLE], activity.rx_busy);
      pin_val_ff.tx_led <= pin_en.tx_led &&
        led_level(live_ind_ff[`CS_BIT_TX_IDLE], activity.tx_busy);
      pin_val_ff.i2c_led <= pin_en.i2c_led &&
        led_level(live_ind_ff[`CS_BIT_I2C_IDLE], activity.i2c_busy);
      pin_val_ff.suspend <= pin_en.suspend &&
        led_level(live_ind_ff[`CS_BIT_SUSPEND_IDLE], activity.suspended);
      pin_val_ff.configured <= pin_en.configured &&
        led_level(live_ind_ff[`CS_BIT_CONFIG_IDLE], activity.configured);
      pin_val_ff.clk_out <= pin_en.clk_out && clk_pin;
    end
  end

  // settings presented to the rest of the chip
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_desc_en_ff <= 1'b0;
      cfg_locked_ff <= 1'b0;
      cfg_password_ff <= 1'b0;
    end else begin
      serial_desc_en_ff <= live_ind_ff[`CS_BIT_SERIAL_EN];
      cfg_locked_ff <= live_ind_ff[`CS_SEC_HI];
      cfg_password_ff <= !live_ind_ff[`CS_SEC_HI] && live_ind_ff[`CS_SEC_LO];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_ref_level_ff <= 2'h0;
      dac_ref_internal_ff <= 1'b0;
      dac_init_value_ff <= 5'h00;
    end else begin
      dac_ref_level_ff <= live_dac_ff[`CS_DACREF_HI:`CS_DACREF_LO];
      dac_ref_internal_ff <= live_dac_ff[`CS_BIT_DAC_SRC];
      dac_init_value_ff <= live_dac_ff[`CS_DACVAL_HI:0];
    end
  end
endmodule

/* File: cs_defines.svh */
// offsets, field positions, codes and reset values of the settings readout
`ifndef CS_DEFINES_SVH
`define CS_DEFINES_SVH
`define CS_CMD_READ_FLASH 8'hB0
`define CS_SUB_CHIP_SETTINGS 8'h00
`define CS_STATUS_OK 8'h00
`define CS_STATUS_UNSUPPORTED 8'h01
`define CS_STRUCT_LEN 8'h0E
`define CS_REPORT_LEN 7'h40
`define CS_OFS_INDICATOR 7'h04
`define CS_OFS_CLKDIV 7'h05
`define CS_OFS_DAC 7'h06
`define CS_MEM_IDX_INDICATOR 3'h0
`define CS_MEM_IDX_CLKDIV 3'h1
`define CS_MEM_IDX_DAC 3'h2
`define CS_BIT_SERIAL_EN 7
`define CS_BIT_RX_IDLE 6
`define CS_BIT_TX_IDLE 5
`define CS_BIT_I2C_IDLE 4
`define CS_BIT_SUSPEND_IDLE 3
`define CS_BIT_CONFIG_IDLE 2
`define CS_SEC_HI 1
`define CS_SEC_LO 0
`define CS_CLKDIV_HI 4
`define CS_DACREF_HI 7
`define CS_DACREF_LO 6
`define CS_BIT_DAC_SRC 5
`define CS_DACVAL_HI 4
`define CS_SETTING_RESET 8'h00
`endif

/* File: cs_pkg.sv */
// types shared by the settings readout modules
package cs_pkg;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } cs_byte_t;
  typedef struct packed {
    logic wr_en;
    logic [2:0] addr;
    logic [7:0] data;
  } cs_nvm_wr_t;
  typedef struct packed {
    logic rx_busy;
    logic tx_busy;
    logic i2c_busy;
    logic suspended;
    logic configured;
  } cs_activity_t;
  typedef struct packed {
    logic rx_led;
    logic tx_led;
    logic i2c_led;
    logic suspend;
    logic configured;
    logic clk_out;
  } cs_pin_en_t;
  typedef enum logic [1:0] {
    CS_RECV,
    CS_FETCH,
    CS_SEND,
    CS_SKIP
  } cs_state_t;
endpackage

/* File: cs_settings_mem.sv */
// nonvolatile settings store with registered read port
`include "cs_defines.svh"
module cs_settings_mem
  import cs_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data_ff
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= `CS_SETTING_RESET;
    end else begin
      rd_data_ff <= mem[rd_addr];
    end
  end
endmodule

/* File: cs_clk_div.sv */
// clock output divider producing a square wave from the core clock while enabled
module cs_clk_div
  import cs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [4:0] divider,
  output logic clk_out_ff
);
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic tick;

  // zero divider behaves as one
  always_comb begin
    tick = 1'b0;
    nxt_cnt = cnt_ff + 5'h01;
    if (cnt_ff + 5'h01 >= divider) begin
      tick = 1'b1;
      nxt_cnt = 5'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 5'h00;
    end else if (!enable) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_ff <= 1'b0;
    end else if (!enable) begin
      clk_out_ff <= 1'b0;
    end else if (tick) begin
      clk_out_ff <= ~clk_out_ff;
    end
  end
endmodule

/* File: cs_readout_checker.sv */
// port assertions for the settings readout
module cs_readout_checker
  import cs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire cs_byte_t cmd_in,
  input wire logic cmd_ready_ff,
  input wire cs_byte_t rsp_out_ff,
  input wire logic rsp_ready,
  input wire cs_nvm_wr_t nvm_wr,
  input wire cs_activity_t activity,
  input wire cs_pin_en_t pin_en,
  input wire cs_pin_en_t pin_oe_ff,
  input wire cs_pin_en_t pin_val_ff,
  input wire logic serial_desc_en_ff,
  input wire logic cfg_locked_ff,
  input wire logic cfg_password_ff,
  input wire logic [1:0] dac_ref_level_ff,
  input wire logic dac_ref_internal_ff,
  input wire logic [4:0] dac_init_value_ff
);
  logic [7:0] ind_ff;
  logic [2:0] wcnt_ff;
  logic [6:0] idx_ff;
  logic first_ff;
  logic [7:0] cmd0_ff;
  wire take = cmd_in.valid && cmd_ready_ff;
  wire [7:0] b0 = first_ff ? cmd_in.data : cmd0_ff;
  wire [4:0] exp_pins = pin_en[5:1] & (activity ^ ind_ff[6:2]);
  // shadow of the indicator byte and settle window
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_ff <= 8'h00;
      wcnt_ff <= 3'h0;
    end else if (nvm_wr.wr_en) begin
      wcnt_ff <= 3'h5;
      if (nvm_wr.addr == 3'h0) ind_ff <= nvm_wr.data;
    end else if (wcnt_ff != 3'h0) begin
      wcnt_ff <= wcnt_ff - 3'h1;
    end
  end
  // response byte index
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) idx_ff <= 7'h00;
    else if (rsp_out_ff.valid && rsp_ready) idx_ff <= rsp_out_ff.last ? 7'h00 : idx_ff + 7'h01;
  end
  // first byte of each command report
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_ff <= 1'b1;
      cmd0_ff <= 8'h00;
    end else if (take) begin
      first_ff <= cmd_in.last;
      if (first_ff) cmd0_ff <= cmd_in.data;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_echo;
    $rose(rsp_out_ff.valid) |-> rsp_out_ff.data == 8'hB0;
  endproperty
  a_echo: assert property (p_echo) else $error("response does not open with echo");
  property p_hold;
    rsp_out_ff.valid && !rsp_ready |=> rsp_out_ff == $past(rsp_out_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("response byte changed while stalled");
  property p_last;
    rsp_out_ff.valid |-> rsp_out_ff.last == (idx_ff == 7'd63);
  endproperty
  a_last: assert property (p_last) else $error("last flag not on byte 63");
  property p_lat;
    take && cmd_in.last && b0 == 8'hB0 |=> (!rsp_out_ff.valid) [*4] ##[1:3] rsp_out_ff.valid;
  endproperty
  a_lat: assert property (p_lat) else $error("read command answer late or early");
  property p_busy;
    take && cmd_in.last && b0 == 8'hB0 |=> !cmd_ready_ff;
  endproperty
  a_busy: assert property (p_busy) else $error("command bus still ready while answering");
  property p_drop;
    take && cmd_in.last && b0 != 8'hB0 |=> (!rsp_out_ff.valid) [*8];
  endproperty
  a_drop: assert property (p_drop) else $error("foreign command answered");
  property p_ind;
    nvm_wr.wr_en && nvm_wr.addr == 3'h0 |-> ##3 serial_desc_en_ff == $past(nvm_wr.data[7], 3)
      && cfg_locked_ff == $past(nvm_wr.data[1], 3)
      && cfg_password_ff == ($past(nvm_wr.data[1:0], 3) == 2'b01);
  endproperty
  a_ind: assert property (p_ind) else $error("serial or security output wrong");
  property p_dac;
    nvm_wr.wr_en && nvm_wr.addr == 3'h2 |-> ##3
      {dac_ref_level_ff, dac_ref_internal_ff, dac_init_value_ff} == $past(nvm_wr.data, 3);
  endproperty
  a_dac: assert property (p_dac) else $error("dac outputs wrong");
  property p_pins;
    $past(rst_n) && wcnt_ff == 3'h0 |=> pin_val_ff[5:1] == $past(exp_pins);
  endproperty
  a_pins: assert property (p_pins) else $error("indicator pin level wrong");
  property p_oe;
    $past(rst_n) |-> pin_oe_ff == $past(pin_en);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable not following assignment");
  c_stall: cover property (rsp_out_ff.valid && !rsp_ready);
  c_drop: cover property (take && cmd_in.last && b0 != 8'hB0);
  c_clk: cover property ($rose(pin_val_ff.clk_out));
endmodule

bind cs_readout cs_readout_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .cmd_in(cmd_in),
  .cmd_ready_ff(cmd_ready_ff), .rsp_out_ff(rsp_out_ff), .rsp_ready(rsp_ready), .nvm_wr(nvm_wr),
  .activity(activity), .pin_en(pin_en), .pin_oe_ff(pin_oe_ff), .pin_val_ff(pin_val_ff),
  .serial_desc_en_ff(serial_desc_en_ff), .cfg_locked_ff(cfg_locked_ff),
  .cfg_password_ff(cfg_password_ff), .dac_ref_level_ff(dac_ref_level_ff),
  .dac_ref_internal_ff(dac_ref_internal_ff), .dac_init_value_ff(dac_init_value_ff));

/* File: cs_host_model.sv */
// host side: sends command reports, drains responses
module cs_host_model
  import cs_pkg::*;
(
  input wire logic core_clk,
  output cs_byte_t cmd_in,
  input wire logic cmd_ready,
  input wire cs_byte_t rsp,
  output logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rbuf [64];
  int rcnt;
  logic slow;
  initial begin
    cmd_in = '0;
    rsp_ready = 1'b1;
    rcnt = 0;
    slow = 1'b0;
  end
  task automatic send(input logic [7:0] code, input logic [7:0] sub);
    rcnt = 0;
    for (int i = 0; i < 64; i++) begin
      @(negedge core_clk);
      cmd_in.valid = 1'b1;
      cmd_in.last = (i == 63);
      cmd_in.data = (i == 0) ? code : (i == 1) ? sub : 8'h00;
      // ready looked at off the edge, where it has settled
      while (!cmd_ready) @(negedge core_clk);
      @(posedge core_clk);
    end
    @(negedge core_clk);
    cmd_in.valid = 1'b0;
    cmd_in.last = 1'b0;
    cmd_in.data = ~cmd_in.data;
  endtask
  // stall every other cycle when slow
  always @(negedge core_clk) rsp_ready <= !slow || !rsp_ready;
  always @(posedge core_clk) begin
    if (rsp.valid && rsp_ready) begin
      rbuf[rcnt[5:0]] <= rsp.data;
      rcnt <= rcnt + 1;
    end
  end
endmodule

/* File: testbench.sv */
// self-checking bench for the settings readout
module testbench
  import cs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, cmd_ready_ff, rsp_ready, serial_desc_en_ff;
  logic cfg_locked_ff, cfg_password_ff, dac_ref_internal_ff;
  logic [1:0] dac_ref_level_ff;
  logic [4:0] dac_init_value_ff;
  cs_byte_t cmd_in, rsp_out_ff;
  cs_nvm_wr_t nvm_wr;
  cs_activity_t activity;
  cs_pin_en_t pin_en, pin_oe_ff, pin_val_ff;
  int num_errors, samples_checked, cyc;
  cs_readout dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_in(cmd_in),
    .cmd_ready_ff(cmd_ready_ff), .rsp_out_ff(rsp_out_ff), .rsp_ready(rsp_ready),
    .nvm_wr(nvm_wr), .activity(activity), .pin_en(pin_en), .pin_oe_ff(pin_oe_ff),
    .pin_val_ff(pin_val_ff), .serial_desc_en_ff(serial_desc_en_ff),
    .cfg_locked_ff(cfg_locked_ff), .cfg_password_ff(cfg_password_ff),
    .dac_ref_level_ff(dac_ref_level_ff), .dac_ref_internal_ff(dac_ref_internal_ff),
    .dac_init_value_ff(dac_init_value_ff));
  cs_host_model host (.core_clk(core_clk), .cmd_in(cmd_in), .cmd_ready(cmd_ready_ff),
    .rsp(rsp_out_ff), .rsp_ready(rsp_ready));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic summarize;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    chk_val({8'h00, e}, {8'h00, g});
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk);
    nvm_wr = '{1'b1, a, d};
    @(negedge core_clk);
    nvm_wr.wr_en = 1'b0;
  endtask
  task automatic wait_rsp;
    for (int i = 0; i < 400 && host.rcnt < 64; i++) @(negedge core_clk);
    chk_val(16'h0040, 16'(host.rcnt));
  endtask
  task automatic sc_read(input logic [7:0] b4, b5, b6, input logic s);
    wr(3'h0, b4);
    wr(3'h1, b5);
    wr(3'h2, b6);
    host.slow = s;
    host.send(8'hB0, 8'h00);
    chk_val(16'h0000, {15'h0, cmd_ready_ff});
    wait_rsp;
    chk_val(16'h0001, {15'h0, cmd_ready_ff});
    chk_byte(8'hB0, host.rbuf[0]);
    chk_byte(8'h00, host.rbuf[1]);
    chk_byte(8'h0E, host.rbuf[2]);
    chk_byte(b4, host.rbuf[4]);
    chk_byte({3'h0, b5[4:0]}, host.rbuf[5]);
    chk_byte(b6, host.rbuf[6]);
    for (int k = 7; k < 64; k++) chk_byte(8'h00, host.rbuf[k]);
    chk_val({5'h0, b4[7], b4[1], b4[1:0] == 2'b01, b6}, {5'h0, serial_desc_en_ff, cfg_locked_ff,
      cfg_password_ff, dac_ref_level_ff, dac_ref_internal_ff, dac_init_value_ff});
    host.slow = 1'b0;
  endtask
  task automatic sc_other;
    host.send(8'hB0, 8'h07);
    wait_rsp;
    chk_byte(8'hB0, host.rbuf[0]);
    chk_byte(8'h01, host.rbuf[1]);
    for (int k = 2; k < 64; k++) chk_byte(8'h00, host.rbuf[k]);
    host.send(8'h51, 8'h00);
    repeat (20) @(negedge core_clk);
    chk_val(16'h0000, 16'(host.rcnt));
  endtask
  task automatic sc_pins;
    logic [4:0] en;
    wr(3'h0, 8'h54);
    repeat (6) @(negedge core_clk);
    for (int k = 0; k < 64; k++) begin
      en = k[5] ? 5'h1F : 5'h0A;
      activity = cs_activity_t'(k[4:0]);
      pin_en = {en, 1'b0};
      @(negedge core_clk);
      chk_val({11'h0, en & (k[4:0] ^ 5'h15)}, {11'h0, pin_val_ff[5:1]});
      chk_val({10'h0, en, 1'b0}, {10'h0, pin_oe_ff});
    end
  endtask
  task automatic sc_clk;
    int n;
    wr(3'h1, 8'hE3);
    pin_en = 6'h01;
    for (int i = 0; i < 50 && !pin_val_ff.clk_out; i++) @(negedge core_clk);
    for (int i = 0; i < 50 && pin_val_ff.clk_out; i++) @(negedge core_clk);
    n = 0;
    for (int i = 0; i < 50 && !pin_val_ff.clk_out; i++) n++;
    while (n < 60 && !pin_val_ff.clk_out) begin
      @(negedge core_clk);
      n++;
    end
    while (n < 60 && pin_val_ff.clk_out) begin
      @(negedge core_clk);
      n++;
    end
    chk_val(16'h0006, 16'(n - 50));
    pin_en = 6'h00;
    repeat (2) @(negedge core_clk);
    chk_val(16'h0000, {15'h0, pin_val_ff.clk_out});
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    rst_n = 1'b0;
    nvm_wr = '0;
    activity = '0;
    pin_en = '0;
    num_errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    sc_read(8'h83, 8'hFF, 8'hFF, 1'b0);
    sc_read(8'h56, 8'h00, 8'h80, 1'b1);
    sc_read(8'h29, 8'h05, 8'h55, 1'b0);
    sc_read(8'h7C, 8'hE3, 8'h2A, 1'b1);
    sc_other;
    sc_pins;
    sc_clk;
    summarize;
  end
endmodule
